/* File: design/ecph_fifo.v */
// Parameterised synchronous FIFO with valid and ready on both sides.
`timescale 1ns/1ps
module ecph_fifo #(
  parameter WIDTH = 9,
  parameter DEPTH = 32,
  parameter AW    = 5
) (
  input  wire             i_clk,
  input  wire             i_rstn,
  input  wire             i_valid,
  output wire             o_ready,
  input  wire [WIDTH-1:0] i_data,
  output wire             o_valid,
  input  wire             i_ready,
  output wire [WIDTH-1:0] o_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wp_q;
  reg [AW-1:0]    rp_q;
  reg [AW:0]      cnt_q;
  wire            wr;
  wire            rd;

  // Full and empty come straight from the occupancy count.
  assign o_ready = (cnt_q != DEPTH[AW:0]);
  assign o_valid = (cnt_q != {(AW+1){1'b0}});
  assign wr      = i_valid && o_ready;
  assign rd      = o_valid && i_ready;
  assign o_data  = mem[rp_q];

  // Storage has no reset; only the pointers and the count need a defined value.
  always @(posedge i_clk) begin
    if (wr) begin
      mem[wp_q] <= i_data;
    end
  end

  // Pointer and count upkeep.
  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      wp_q  <= {AW{1'b0}};
      rp_q  <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end else begin
      if (wr) begin
        wp_q <= (wp_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wp_q + 1'b1;
      end
      if (rd) begin
        rp_q <= (rp_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rp_q + 1'b1;
      end
      if (wr && !rd) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (rd && !wr) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule // ecph_fifo

/* File: design/ecph_port.v */
// Extended-capabilities parallel port direction control and byte handshake.
//
// Operation
// - Direction-select pin follows a control bit: asserted reverse, negated forward.
// - Reverse: assert host ack to ask for a byte, drop it on peripheral strobe.
// - Forward: host ack low marks address or run-length byte, high marks data.
// - Whichever party sends drives the single 8-bit bidirectional data bus.
// - Mode indicator stays negated while the control word selects extended mode.
// - In reset strobes, mode indicator, DMA request float; direction negated (high), data low.
// - Strapping inputs are captured through hard reset and the configuration interval as the hardware configuration.
// - Direction/game pin is an input during configuration, then driven high.
// - Forward latch strobe drops on peripheral ack, reasserts only after ack clears.
`timescale 1ns/1ps
`include "ecph_defs.vh"
module ecph_port #(
  parameter STRAP_W = `ECPH_STRAP_W,
  parameter DEPTH   = `ECPH_FIFO_DEPTH,
  parameter AW      = 5
) (
  input  wire                       i_clk,
  input  wire                       i_rstn,
  input  wire [`ECPH_CTL_WIDTH-1:0] i_port_control_reg,
  output reg  [`ECPH_ST_WIDTH-1:0]  o_port_status_reg,
  input  wire                       i_tx_valid,
  output wire                       o_tx_ready,
  input  wire [7:0]                 i_tx_data,
  input  wire                       i_tx_is_addr,
  output wire                       o_rx_valid,
  input  wire                       i_rx_ready,
  output wire [7:0]                 o_rx_data,
  output wire                       o_rx_is_rle,
  input  wire [STRAP_W-1:0]         i_strap,
  output reg  [STRAP_W-1:0]         o_hw_config,
  output wire                       o_config_done,
  input  wire [7:0]                 i_port_data_bus,
  output wire [7:0]                 o_port_data_bus,
  output wire                       o_port_data_bus_oe,
  output wire                       o_forward_latch_strobe_n,
  output wire                       o_forward_latch_strobe_oe,
  output wire                       o_host_ack_line_n,
  output wire                       o_host_ack_line_oe,
  output wire                       o_mode_indicator_line_n,
  output wire                       o_mode_indicator_line_oe,
  output wire                       o_port_dma_request,
  output wire                       o_port_dma_request_oe,
  output wire                       o_direction_select_n,
  input  wire                       i_port_dir_or_game_select,
  output wire                       o_port_dir_or_game_select,
  output wire                       o_port_dir_or_game_select_oe,
  input  wire                       i_peripheral_acknowledge,
  input  wire                       i_reverse_data_valid_strobe_n,
  input  wire                       i_reverse_transfer_request_n,
  input  wire                       i_ack_reverse_line
);
  localparam ST_IDLE   = 3'h0;
  localparam ST_FSTRB  = 3'h1;
  localparam ST_FWAIT  = 3'h2;
  localparam ST_RASK   = 3'h3;
  localparam ST_RHOLD  = 3'h4;
  localparam integer CFG_CYC_I = `ECPH_CFG_CYC;
  localparam [7:0]   CFG_CYC   = CFG_CYC_I[7:0];

  reg  [2:0]         st_q;
  reg  [2:0]         st_d;
  reg  [7:0]         pd_q;
  reg                addr_q;
  reg                live_q;
  reg  [7:0]         cfg_cnt_q;
  reg                cfg_done_q;
  reg  [3:0]         s1_q;
  reg  [3:0]         s2_q;
  wire [3:0]         raw;
  wire               ack_s;
  wire               clk_n_s;
  wire               req_n_s;
  wire               grant_s;
  wire               rev_sel;
  wire               ecp_on;
  wire               tx_v;
  wire               tx_take;
  wire [8:0]         tx_q;
  wire               rx_wr;
  wire               rx_rdy;

  // The four peripheral handshake inputs are asynchronous to i_clk, so each goes through two flops; the data bus is not synchronised.
  assign raw = {i_ack_reverse_line, i_reverse_transfer_request_n,
                i_reverse_data_valid_strobe_n, i_peripheral_acknowledge};
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_sync
      always @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
          s1_q[g] <= 1'b1;
          s2_q[g] <= 1'b1;
        end else begin
          s1_q[g] <= raw[g];
          s2_q[g] <= s1_q[g];
        end
      end
    end
  endgenerate
  assign ack_s   = s2_q[0];
  assign clk_n_s = s2_q[1];
  assign req_n_s = s2_q[2];
  assign grant_s = s2_q[3];

  assign rev_sel = i_port_control_reg[`ECPH_CTL_DIR_BIT];
  assign ecp_on  = i_port_control_reg[`ECPH_CTL_ECP_BIT];

  // Status word shows live synchronised peripheral levels and the engine's busy state.
  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_port_status_reg <= {`ECPH_ST_WIDTH{1'b0}};
    end else begin
      o_port_status_reg[`ECPH_ST_REQ_BIT]   <= ~req_n_s;
      o_port_status_reg[`ECPH_ST_GRANT_BIT] <= grant_s;
      o_port_status_reg[`ECPH_ST_BUSY_BIT]  <= (st_q != ST_IDLE);
    end
  end

  // Strap capture runs while reset is held and until the configuration interval ends; the captured register itself has no async reset.
  always @(posedge i_clk) begin
    if (!cfg_done_q) begin
      o_hw_config <= i_strap;
    end
  end

  // Configuration interval timer after reset release.
  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      cfg_cnt_q  <= 8'h00;
      cfg_done_q <= 1'b0;
    end else if (!cfg_done_q) begin
      cfg_cnt_q <= cfg_cnt_q + 8'h01;
      if (cfg_cnt_q == CFG_CYC - 8'h01) begin
        cfg_done_q <= 1'b1;
      end
    end
  end
  assign o_config_done                 = cfg_done_q;
  assign o_port_dir_or_game_select     = 1'b1;
  assign o_port_dir_or_game_select_oe  = cfg_done_q;

  // Outbound bytes queue here so the source is stalled by the slow cable only when the queue is full.
  ecph_fifo #(.WIDTH(9), .DEPTH(DEPTH), .AW(AW)) u_tx_fifo (
    .i_clk   (i_clk),
    .i_rstn  (i_rstn),
    .i_valid (i_tx_valid),
    .o_ready (o_tx_ready),
    .i_data  ({i_tx_is_addr, i_tx_data}),
    .o_valid (tx_v),
    .i_ready (tx_take),
    .o_data  (tx_q)
  );

  // Inbound bytes queue here; a full queue holds off the next host-ack request.
  ecph_fifo #(.WIDTH(9), .DEPTH(DEPTH), .AW(AW)) u_rx_fifo (
    .i_clk   (i_clk),
    .i_rstn  (i_rstn),
    .i_valid (rx_wr),
    .o_ready (rx_rdy),
    .i_data  ({ack_s, i_port_data_bus}),
    .o_valid (o_rx_valid),
    .i_ready (i_rx_ready),
    .o_data  ({o_rx_is_rle, o_rx_data})
  );

  assign tx_take = (st_q == ST_IDLE) && ecp_on && !rev_sel && tx_v && !ack_s;
  // Data bus is sampled on the synchronised strobe; it was stable two cycles before.
  assign rx_wr   = (st_q == ST_RASK) && !clk_n_s;

  // Byte handshake engine for both directions.
  always @* begin
    st_d = st_q;
    case (st_q)
      ST_IDLE: begin
        if (!ecp_on || !cfg_done_q) begin
          st_d = ST_IDLE;
        end else if (rev_sel) begin
          if (rx_rdy && clk_n_s && !grant_s) begin
            st_d = ST_RASK;
          end
        end else if (tx_take) begin
          st_d = ST_FSTRB;
        end
      end
      ST_FSTRB: begin
        if (ack_s) begin
          st_d = ST_FWAIT;
        end
      end
      ST_FWAIT: begin
        if (!ack_s) begin
          st_d = ST_IDLE;
        end
      end
      ST_RASK: begin
        if (!clk_n_s) begin
          st_d = ST_RHOLD;
        end
      end
      ST_RHOLD: begin
        if (clk_n_s) begin
          st_d = ST_IDLE;
        end
      end
      default: begin
        st_d = ST_IDLE;
      end
    endcase
  end

  // State, outgoing byte and its address qualifier.
  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      st_q   <= ST_IDLE;
      pd_q   <= 8'h00;
      addr_q <= 1'b0;
      live_q <= 1'b0;
    end else begin
      st_q   <= st_d;
      live_q <= cfg_done_q;
      if (tx_take) begin
        pd_q   <= tx_q[7:0];
        addr_q <= tx_q[8];
      end
    end
  end

  // Data bus is driven low in reset and with the outgoing byte while forward; released in reverse.
  assign o_port_data_bus    = pd_q;
  assign o_port_data_bus_oe = !(live_q && rev_sel);

  // Strobes float during reset and come alive with the port afterwards.
  assign o_forward_latch_strobe_n  = !(st_q == ST_FSTRB);
  assign o_forward_latch_strobe_oe = live_q;
  assign o_host_ack_line_n         = rev_sel ? !(st_q == ST_RASK) : !addr_q;
  assign o_host_ack_line_oe        = live_q;
  assign o_mode_indicator_line_n   = !(live_q && !ecp_on) ? 1'b1 : 1'b0;
  assign o_mode_indicator_line_oe  = live_q;
  assign o_port_dma_request        = 1'b0;
  assign o_port_dma_request_oe     = live_q;
  assign o_direction_select_n      = !(live_q && rev_sel);
endmodule // ecph_port

/* File: pkg/ecph_defs.vh */
// Constants shared by the parallel port direction and handshake block.
`ifndef ECPH_DEFS_VH
`define ECPH_DEFS_VH
// Control word field positions.
`define ECPH_CTL_DIR_BIT      0
`define ECPH_CTL_ECP_BIT      1
`define ECPH_CTL_ADDR_BIT     2
`define ECPH_CTL_WIDTH        3
`define ECPH_CTL_RESET        3'h0
// Status word field positions.
`define ECPH_ST_REQ_BIT       0
`define ECPH_ST_GRANT_BIT     1
`define ECPH_ST_BUSY_BIT      2
`define ECPH_ST_WIDTH         3
// Configuration interval after reset release, in ns, and its cycle count at 100 MHz.
`define ECPH_CFG_NS           200
`define ECPH_CLK_NS           10
`define ECPH_CFG_CYC          ((`ECPH_CFG_NS + `ECPH_CLK_NS - 1) / `ECPH_CLK_NS)
`define ECPH_STRAP_W          8
`define ECPH_FIFO_DEPTH       32
`endif

/* File: test/ecph_checker.sv */
// Concurrent checks on the port pins of the handshake block.
`timescale 1ns/1ps
module ecph_checker (
  input logic       i_clk,
  input logic       i_rstn,
  input logic [2:0] i_port_control_reg,
  input logic       i_peripheral_acknowledge,
  input logic       i_reverse_data_valid_strobe_n,
  input logic       o_forward_latch_strobe_n,
  input logic       o_forward_latch_strobe_oe,
  input logic       o_host_ack_line_n,
  input logic       o_host_ack_line_oe,
  input logic       o_mode_indicator_line_n,
  input logic       o_mode_indicator_line_oe,
  input logic       o_port_dma_request_oe,
  input logic [7:0] o_port_data_bus,
  input logic       o_port_data_bus_oe,
  input logic       o_direction_select_n,
  input logic       o_config_done
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  // The edge after release still sees the reset pin levels.
  a_reset_pin_state:
    assert property ($rose(i_rstn) |-> !o_forward_latch_strobe_oe && !o_host_ack_line_oe
      && !o_mode_indicator_line_oe && !o_port_dma_request_oe && o_port_data_bus_oe
      && o_port_data_bus == 8'h00 && o_direction_select_n) else $error("bad reset pins");
  // A steady reverse select must show on the pin.
  a_dir_reverse:
    assert property ((i_port_control_reg[0]) [*3] |-> !o_direction_select_n)
      else $error("direction pin not reverse");
  a_mode_negated:
    assert property ((o_config_done && i_port_control_reg[1]) [*3]
      |-> o_mode_indicator_line_oe && o_mode_indicator_line_n) else $error("mode line on");
  // Acknowledge goes through two flops, so the strobe may not react at once.
  a_strobe_release:
    assert property ($rose(i_peripheral_acknowledge) && !o_forward_latch_strobe_n
      |=> !o_forward_latch_strobe_n ##[1:3] o_forward_latch_strobe_n)
      else $error("strobe release timing");
  a_strobe_rearm:
    assert property ($fell(o_forward_latch_strobe_n) |-> !i_peripheral_acknowledge
      && !$past(i_peripheral_acknowledge)) else $error("strobe while ack high");
  a_ask_release:
    assert property ($fell(i_reverse_data_valid_strobe_n) && !o_host_ack_line_n
      && !o_direction_select_n |=> !o_host_ack_line_n ##[1:3] o_host_ack_line_n)
      else $error("host ack release timing");
  a_fwd_bus_drive:
    assert property (!o_forward_latch_strobe_n |-> o_port_data_bus_oe)
      else $error("bus not driven");
  a_rev_bus_float:
    assert property (!o_direction_select_n && !o_host_ack_line_n |-> !o_port_data_bus_oe)
      else $error("bus driven in reverse");
  a_fwd_data_hold:
    assert property (!o_forward_latch_strobe_n && $past(!o_forward_latch_strobe_n)
      |-> $stable(o_port_data_bus)) else $error("data moved under strobe");
endmodule // ecph_checker
bind ecph_port ecph_checker CHK (.*);

/* File: test/ecph_periph.sv */
// Behavioural peripheral on the far side of the parallel cable.
`timescale 1ns/1ps
module ecph_periph (
  input  logic       i_clk,
  input  logic       i_strobe_n,
  input  logic       i_host_ack_n,
  input  logic       i_dir_n,
  input  logic [7:0] i_bus,
  output logic       o_ack,
  output logic       o_rstb_n,
  output logic       o_req_n,
  output logic       o_grant,
  output logic [7:0] o_bus
);
  logic [8:0] rxq[$];
  logic [8:0] txq[$];
  int         dly = 1;
  // Released bus toggles so a stale byte can never pass for a real one.
  initial begin
    {o_ack, o_rstb_n, o_req_n, o_grant, o_bus} = {4'h7, 8'h5A};
    forever begin
      @(negedge i_clk);
      if (!i_strobe_n) begin
        repeat (dly) @(negedge i_clk);
        rxq.push_back({!i_host_ack_n, i_bus});
        o_ack = 1'b1;
        while (!i_strobe_n) @(negedge i_clk);
        repeat (dly) @(negedge i_clk);
        o_ack = 1'b0;
      end else if (!i_dir_n && !i_host_ack_n && txq.size() > 0) begin
        {o_ack, o_bus} = txq.pop_front();
        repeat (dly + 3) @(negedge i_clk);
        o_rstb_n = 1'b0;
        while (!i_host_ack_n) @(negedge i_clk);
        o_rstb_n = 1'b1;
        @(negedge i_clk);
        o_ack = 1'b0;
      end
      o_bus = ~o_bus;
    end
  end
  // Request and grant lines are plain levels.
  always @(negedge i_clk) begin
    o_req_n <= (txq.size() == 0);
    o_grant <= i_dir_n;
  end
endmodule // ecph_periph

/* File: test/tb_top.sv */
// Self-checking bench for the parallel port handshake block.
`timescale 1ns/1ps
`include "ecph_defs.vh"
module tb_top;
  logic       i_clk, i_rstn, i_tx_valid, i_tx_is_addr, i_rx_ready, o_tx_ready;
  logic [2:0] i_port_control_reg, o_port_status_reg;
  logic [7:0] i_tx_data, i_strap, o_hw_config, o_rx_data, o_port_data_bus, pb;
  logic       o_rx_valid, o_rx_is_rle, o_config_done, o_port_data_bus_oe;
  logic       o_forward_latch_strobe_n, o_forward_latch_strobe_oe, o_host_ack_line_n;
  logic       o_host_ack_line_oe, o_mode_indicator_line_n, o_mode_indicator_line_oe;
  logic       o_port_dma_request, o_port_dma_request_oe, o_direction_select_n;
  logic       o_port_dir_or_game_select, o_port_dir_or_game_select_oe;
  logic       i_peripheral_acknowledge, i_reverse_data_valid_strobe_n;
  logic       i_reverse_transfer_request_n, i_ack_reverse_line;
  wire  [7:0] i_port_data_bus = o_port_data_bus_oe ? o_port_data_bus : pb;
  wire        i_port_dir_or_game_select = o_port_dir_or_game_select_oe;
  int         failures = 0;
  int         total_checks = 0;
  int         n;
  ecph_port DUT (.*);
  ecph_periph PER (.i_clk(i_clk), .i_strobe_n(o_forward_latch_strobe_n),
    .i_host_ack_n(o_host_ack_line_n), .i_dir_n(o_direction_select_n), .i_bus(i_port_data_bus),
    .o_ack(i_peripheral_acknowledge), .o_rstb_n(i_reverse_data_valid_strobe_n),
    .o_req_n(i_reverse_transfer_request_n), .o_grant(i_ack_reverse_line), .o_bus(pb));
  // Free-running 100 MHz clock.
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Reset pins, strap capture and the configuration interval.
  task automatic t_reset;
    chk({o_port_data_bus_oe, o_port_data_bus}, 9'h100);
    chk({o_direction_select_n, o_port_dir_or_game_select_oe}, 9'h002);
    i_rstn = 1'b1;
    n = 0;
    while (o_config_done !== 1'b1) begin
      n++;
      @(negedge i_clk);
    end
    chk(n[8:0], 9'h014);
    chk({o_port_dir_or_game_select_oe, o_port_dir_or_game_select}, 9'h003);
    i_strap = 8'h3C;
    repeat (3) @(negedge i_clk);
    chk(o_hw_config, 9'h0A5);
    $display("test reset done");
  endtask
  // Fill the outbound buffer while the port is off, then drain it past a slow peripheral.
  task automatic t_fill;
    PER.dly = 4;
    i_tx_valid = 1'b1;
    for (n = 0; n < 40; n++) begin
      i_tx_data = n[7:0];
      i_tx_is_addr = (n[1:0] == 2'h1);
      if (o_tx_ready !== 1'b1)
        break;
      @(negedge i_clk);
    end
    i_tx_valid = 1'b0;
    chk(n[8:0], 9'h020);
    repeat (10) @(negedge i_clk);
    chk(PER.rxq.size(), 9'h000);
    i_port_control_reg = 3'h2;
    while (PER.rxq.size() < 32) @(negedge i_clk);
    chk(o_mode_indicator_line_n, 9'h001);
    chk({o_port_dma_request, o_port_dma_request_oe}, 9'h001);
    for (n = 0; n < 32; n++)
      chk(PER.rxq[n], {n[1:0] == 2'h1, n[7:0]});
    $display("test fill done");
  endtask
  // Two reverse bytes, the first one a run-length count.
  task automatic t_reverse;
    PER.dly = 1;
    PER.txq = '{9'h1C3, 9'h05A};
    // The last forward byte still needs its acknowledge to clear through the synchroniser.
    repeat (20) @(negedge i_clk);
    chk(o_port_status_reg, 9'h003);
    i_port_control_reg = 3'h3;
    i_rx_ready = 1'b1;
    for (n = 0; n < 2; n++) begin
      while (o_rx_valid !== 1'b1) @(negedge i_clk);
      chk({o_rx_is_rle, o_rx_data}, n ? 9'h05A : 9'h1C3);
      @(negedge i_clk);
    end
    i_rx_ready = 1'b0;
    repeat (8) @(negedge i_clk);
    chk({o_direction_select_n, o_port_status_reg[1:0]}, 9'h000);
    $display("test reverse done");
  endtask
  // Main sequence with reset held for 20 cycles.
  initial begin
    {i_rstn, i_tx_valid, i_tx_is_addr, i_rx_ready, i_port_control_reg} = 7'h00;
    {i_tx_data, i_strap} = 16'h00A5;
    repeat (20) @(negedge i_clk);
    t_reset;
    t_fill;
    t_reverse;
    stop_test;
  end
  // Watchdog well beyond the expected run of about six hundred cycles.
  initial begin
    repeat (4000) @(posedge i_clk);
    failures++;
    stop_test;
  end
endmodule // tb_top
